/* File: hdl/cib_bank.sv */
// cib_bank: identification register bank answering coprocessor reads
// assumes one request per cycle from the pipeline; answer one clock later
// Notes on behaviour
// - main id: implementer top byte, variant below
// - cache type format, granules and data line
// - low nibble is instruction line log2 words
// - instruction policy reads 10, bits 13:4 zero
// - tightly coupled memory type reads zero
// - translation buffer: 64 entries two-way, four lockable
// - buffer type: lock counts 0/4, unified flag
// - affinity bit 31 always one
// - affinity bit 30 set when uniprocessor
// - affinity 11:8 from cluster id pins
// - affinity 1:0 is core number 0..3 when multicore, zero when uniprocessor
// - other affinity bits read zero
// - opc2 selects feature register; 3 reads zero
// - processor feature 0 states 1,2,3,1
// - debug feature 0 fields 0,1,0,4,4,4
// - single core: configuration base reads zero
// - multicore: configuration base from peripheral base
// - buffer test registers refused when non-secure
// - 32-bit, privileged; id words read-only and shared across states, buffer test registers secure only
`default_nettype none
module cib_bank #(
  parameter logic [7:0] IMPLEMENTER = 8'h5a, // arbitrary identity value
  parameter logic [3:0] MAJOR_REV = 4'h0,
  parameter logic [3:0] ARCH_CODE = 4'hf, // arbitrary identity value
  parameter logic [11:0] PART_NUM = 12'h123, // arbitrary identity value
  parameter logic [3:0] MINOR_REV = 4'h0,
  parameter logic [3:0] WB_GRANULE = 4'h3,
  parameter logic [3:0] EXCL_GRANULE = 4'h3,
  parameter logic [3:0] DLINE_LOG2 = 4'h3,
  parameter logic [3:0] ILINE_LOG2 = 4'h3,
  parameter logic MULTICORE = 1'b1,
  parameter logic [31:0] PF1_VALUE = 32'h0000_0011,
  parameter logic [127:0] MM_VALUES = 128'h0
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire cib_pkg::cib_req_s req,
  input wire logic [3:0] cluster_id_pins,
  input wire logic [1:0] core_number,
  input wire logic [18:0] peripheral_base_input,
  output cib_pkg::cib_rsp_s rsp_r,
  output logic test_wr_r,
  output logic test_rd_r,
  output logic [2:0] test_sel_r
);
  import cib_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic sel(input cib_req_s r, input logic [3:0] crn, input logic [2:0] o1,
                               input logic [3:0] crm, input logic [2:0] o2);
    sel = (r.crn == crn) && (r.opc1 == o1) && (r.crm == crm) && (r.opc2 == o2);
  endfunction

  function automatic logic is_test(input cib_req_s r);
    is_test = sel(r, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_TBW, CIB_OP2_TBW)
           || sel(r, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_TBVA, CIB_OP2_TBRW)
           || sel(r, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_TBPA, CIB_OP2_TBRW)
           || sel(r, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_TBAT, CIB_OP2_TBRW);
  endfunction

  logic [31:0] cfg_base_r;
  logic [31:0] feat_word;
  logic [31:0] rdata_nxt;
  logic undef_nxt;
  logic [31:0] main_id;
  logic [31:0] cache_type;
  logic [31:0] tb_type;
  logic [31:0] affinity;

  // ----------------------------------------------------------------
  // constant words, and affinity from the pins
  // ----------------------------------------------------------------
  assign main_id = {IMPLEMENTER, MAJOR_REV, ARCH_CODE, PART_NUM, MINOR_REV};
  assign cache_type = {CIB_CT_FORMAT, 1'b0, WB_GRANULE, EXCL_GRANULE, DLINE_LOG2,
                       CIB_CT_IPOLICY, 10'h000, ILINE_LOG2};
  assign tb_type = {8'h00, CIB_TBT_ILOCK, CIB_TBT_DLOCK, 7'h00, CIB_TBT_SEPARATE};
  assign affinity = {CIB_AFF_NEWFMT, ~MULTICORE, 18'h00000, cluster_id_pins, 6'h00,
                     (MULTICORE ? core_number : 2'h0)};

  cib_feat_rom u_feat (
    .opc2(req.opc2),
    .pf1_word(PF1_VALUE),
    .mm_words(MM_VALUES),
    .word(feat_word)
  );

  // ----------------------------------------------------------------
  // configuration base captured at reset release
  // ----------------------------------------------------------------
  logic cfg_loaded_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_base_r <= CIB_ZERO;
      cfg_loaded_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r <= 1'b1;
      if (MULTICORE) begin
        cfg_base_r <= {peripheral_base_input, 13'h0000};
      end else begin
        cfg_base_r <= CIB_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and refusal; writes to id words are ignored
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = CIB_ZERO;
    undef_nxt = 1'b0;
    if (!req.privileged) begin
      undef_nxt = 1'b1;
    end else if (is_test(req)) begin
      undef_nxt = !req.secure;
      if (req.write == 1'b0 && sel(req, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_TBW, CIB_OP2_TBW)) begin
        undef_nxt = 1'b1; // write-entry register is write-only
      end
    end else if (sel(req, CIB_CRN_ID, CIB_OPC1_ID, CIB_CRM_MAIN, CIB_OP2_MAIN)) begin
      rdata_nxt = main_id;
    end else if (sel(req, CIB_CRN_ID, CIB_OPC1_ID, CIB_CRM_MAIN, CIB_OP2_CACHE)) begin
      rdata_nxt = cache_type;
    end else if (sel(req, CIB_CRN_ID, CIB_OPC1_ID, CIB_CRM_MAIN, CIB_OP2_TCM)) begin
      rdata_nxt = CIB_ZERO;
    end else if (sel(req, CIB_CRN_ID, CIB_OPC1_ID, CIB_CRM_MAIN, CIB_OP2_TBT)) begin
      rdata_nxt = tb_type;
    end else if (sel(req, CIB_CRN_ID, CIB_OPC1_ID, CIB_CRM_MAIN, CIB_OP2_AFF)) begin
      rdata_nxt = affinity;
    end else if (req.crn == CIB_CRN_ID && req.opc1 == CIB_OPC1_ID && req.crm == CIB_CRM_FEAT) begin
      rdata_nxt = feat_word;
    end else if (sel(req, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_CFG, CIB_OP2_CFG)) begin
      rdata_nxt = cfg_base_r;
    end else begin
      rdata_nxt = CIB_ZERO; // unmapped selections read zero
    end
  end

  // ----------------------------------------------------------------
  // registered answer, same for both security states except buffer test registers, refused when non-secure
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= req.valid;
      rsp_r.undef <= req.valid & undef_nxt;
      rsp_r.rdata <= (req.valid && !req.write && !undef_nxt) ? rdata_nxt : CIB_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // strobes towards the translation buffer test port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_wr_r <= 1'b0;
      test_rd_r <= 1'b0;
      test_sel_r <= 3'h0;
    end else begin
      test_wr_r <= req.valid && req.privileged && req.secure && is_test(req) && req.write;
      test_rd_r <= req.valid && req.privileged && req.secure && is_test(req) && !req.write
                   && !sel(req, CIB_CRN_CFG, CIB_OPC1_CFG, CIB_CRM_TBW, CIB_OP2_TBW);
      test_sel_r <= req.crm[2:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_id_read(logic [2:0] o2);
    req.valid && req.privileged && !req.write && req.crn == CIB_CRN_ID && req.opc1 == CIB_OPC1_ID
      && req.crm == CIB_CRM_MAIN && req.opc2 == o2;
  endsequence

  a_main_id_top: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_MAIN) |=> rsp_r.rdata[31:20] == {IMPLEMENTER, MAJOR_REV})
    else $error("main id top fields wrong");
  a_cache_fmt: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_CACHE) |=> rsp_r.rdata[31:28] == 4'h8 && rsp_r.rdata[19:16] == DLINE_LOG2)
    else $error("cache type format wrong");
  a_cache_iline: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_CACHE) |=> rsp_r.rdata[3:0] == ILINE_LOG2)
    else $error("instruction line field wrong");
  a_cache_policy: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_CACHE) |=> rsp_r.rdata[15:4] == 12'h800)
    else $error("instruction policy wrong");
  a_tcm_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_TCM) |=> rsp_r.rdata == 32'h0 && !rsp_r.undef)
    else $error("tcm type not zero");
  a_tbt_value: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_TBT) |=> rsp_r.rdata == 32'h0000_0400)
    else $error("buffer type wrong");
  a_aff_fmt: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_AFF) |=> rsp_r.rdata[31] && rsp_r.rdata[30] == !MULTICORE)
    else $error("affinity format bits wrong");
  a_aff_cluster: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_AFF) |=> rsp_r.rdata[11:8] == $past(cluster_id_pins))
    else $error("cluster id not reflected");
  a_aff_sbz: assert property (@(posedge clk) disable iff (!rst_n)
    s_id_read(CIB_OP2_AFF) |=> rsp_r.rdata[29:12] == 18'h0 && rsp_r.rdata[7:2] == 6'h0)
    else $error("affinity sbz bits set");
  a_feat_rsv: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.privileged && !req.write && req.crn == CIB_CRN_ID && req.crm == CIB_CRM_FEAT
      && req.opc1 == CIB_OPC1_ID && req.opc2 == CIB_OP2_FRSV |=> rsp_r.rdata == 32'h0)
    else $error("reserved feature slot not zero");
  a_pf0_value: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.privileged && !req.write && req.crn == CIB_CRN_ID && req.crm == CIB_CRM_FEAT
      && req.opc1 == CIB_OPC1_ID && req.opc2 == CIB_OP2_PF0 |=> rsp_r.rdata == 32'h0000_1231)
    else $error("processor feature 0 wrong");
  a_df0_value: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.privileged && !req.write && req.crn == CIB_CRN_ID && req.crm == CIB_CRM_FEAT
      && req.opc1 == CIB_OPC1_ID && req.opc2 == CIB_OP2_DF0 |=> rsp_r.rdata == 32'h0001_0444)
    else $error("debug feature 0 wrong");
  a_test_ns: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && !req.secure && is_test(req) |=> rsp_r.undef && !test_wr_r && !test_rd_r)
    else $error("test register reachable non-secure");
  a_user_refused: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && !req.privileged |=> rsp_r.undef && !test_wr_r && !test_rd_r)
    else $error("user access not refused");
  a_write_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.write |=> rsp_r.rdata == 32'h0 && $stable(cfg_base_r))
    else $error("write had an effect");
endmodule // cib_bank
`default_nettype wire

/* File: hdl/cib_pkg.sv */
// cib_pkg: constants, selectors and carriers for the identification register bank
// assumes a 32-bit coprocessor read/write port driven by the core pipeline
`default_nettype none
package cib_pkg;
  // ----------------------------------------------------------------
  // register selection: primary (crn), opc1, secondary (crm), opc2
  // ----------------------------------------------------------------
  localparam logic [3:0] CIB_CRN_ID = 4'h0;
  localparam logic [3:0] CIB_CRN_CFG = 4'hf;
  localparam logic [2:0] CIB_OPC1_ID = 3'h0;
  localparam logic [2:0] CIB_OPC1_CFG = 3'h4;
  localparam logic [3:0] CIB_CRM_MAIN = 4'h0;
  localparam logic [3:0] CIB_CRM_FEAT = 4'h1;
  localparam logic [3:0] CIB_CRM_CFG = 4'h0;
  localparam logic [3:0] CIB_CRM_TBW = 4'h4;
  localparam logic [3:0] CIB_CRM_TBVA = 4'h5;
  localparam logic [3:0] CIB_CRM_TBPA = 4'h6;
  localparam logic [3:0] CIB_CRM_TBAT = 4'h7;
  localparam logic [2:0] CIB_OP2_MAIN = 3'h0;
  localparam logic [2:0] CIB_OP2_CACHE = 3'h1;
  localparam logic [2:0] CIB_OP2_TCM = 3'h2;
  localparam logic [2:0] CIB_OP2_TBT = 3'h3;
  localparam logic [2:0] CIB_OP2_AFF = 3'h5;
  localparam logic [2:0] CIB_OP2_PF0 = 3'h0;
  localparam logic [2:0] CIB_OP2_PF1 = 3'h1;
  localparam logic [2:0] CIB_OP2_DF0 = 3'h2;
  localparam logic [2:0] CIB_OP2_FRSV = 3'h3;
  localparam logic [2:0] CIB_OP2_MM0 = 3'h4;
  localparam logic [2:0] CIB_OP2_CFG = 3'h0;
  localparam logic [2:0] CIB_OP2_TBW = 3'h4;
  localparam logic [2:0] CIB_OP2_TBRW = 3'h2;
  // ----------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------
  localparam logic [2:0] CIB_CT_FORMAT = 3'h4;
  localparam logic [1:0] CIB_CT_IPOLICY = 2'h2;
  localparam logic [7:0] CIB_TBT_ILOCK = 8'h00;
  localparam logic [7:0] CIB_TBT_DLOCK = 8'h04;
  localparam logic CIB_TBT_SEPARATE = 1'b0;
  localparam int CIB_TB_ENTRIES = 64;
  localparam int CIB_TB_WAYS = 2;
  localparam logic [3:0] CIB_PF0_ST3 = 4'h1;
  localparam logic [3:0] CIB_PF0_ST2 = 4'h2;
  localparam logic [3:0] CIB_PF0_ST1 = 4'h3;
  localparam logic [3:0] CIB_PF0_ST0 = 4'h1;
  localparam logic [3:0] CIB_DF0_MCU_MM = 4'h0;
  localparam logic [3:0] CIB_DF0_TRC_MM = 4'h1;
  localparam logic [3:0] CIB_DF0_TRC_CP = 4'h0;
  localparam logic [3:0] CIB_DF0_CORE_MM = 4'h4;
  localparam logic [3:0] CIB_DF0_SEC_CP = 4'h4;
  localparam logic [3:0] CIB_DF0_CORE_CP = 4'h4;
  localparam logic CIB_AFF_NEWFMT = 1'b1;
  localparam int CIB_CFG_LSB = 13;
  localparam logic [31:0] CIB_ZERO = 32'h0000_0000;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic privileged;
    logic secure;
    logic [3:0] crn;
    logic [2:0] opc1;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } cib_req_s;
  typedef struct packed {
    logic valid;
    logic undef;
    logic [31:0] rdata;
  } cib_rsp_s;
endpackage
`default_nettype wire

/* File: hdl/cib_feat_rom.sv */
// cib_feat_rom: constant processor/debug feature group selected by opc2
// assumes the memory model feature words come in from the core's wider id set
`default_nettype none
module cib_feat_rom (
  input wire logic [2:0] opc2,
  input wire logic [31:0] pf1_word,
  input wire logic [127:0] mm_words,
  output logic [31:0] word
);
  import cib_pkg::*;

  // ----------------------------------------------------------------
  // opc2 decode of the feature group
  // ----------------------------------------------------------------
  always_comb begin
    word = CIB_ZERO;
    if (opc2 == CIB_OP2_PF0) begin
      word = {16'h0000, CIB_PF0_ST3, CIB_PF0_ST2, CIB_PF0_ST1, CIB_PF0_ST0};
    end else if (opc2 == CIB_OP2_PF1) begin
      word = pf1_word;
    end else if (opc2 == CIB_OP2_DF0) begin
      word = {8'h00, CIB_DF0_MCU_MM, CIB_DF0_TRC_MM, CIB_DF0_TRC_CP,
              CIB_DF0_CORE_MM, CIB_DF0_SEC_CP, CIB_DF0_CORE_CP};
    end else if (opc2 == CIB_OP2_FRSV) begin
      word = CIB_ZERO; // reserved slot reads zero
    end else begin
      word = mm_words[32*(opc2 - CIB_OP2_MM0) +: 32];
    end
  end
endmodule // cib_feat_rom
`default_nettype wire

/* File: tb/cib_bank_bench.sv */
// cib_bank_bench: self-checking bench for the identification register bank
// assumes cib_pkg and cib_bank are compiled first; the bench drives every port itself
`default_nettype none
module cib_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cib_pkg::*;
  // ----------------------------------------------------------------
  // configuration and signals
  // ----------------------------------------------------------------
  localparam logic [7:0] IMPL = 8'h5a; // arbitrary identity value
  localparam logic [3:0] MREV = 4'h2;
  localparam logic [3:0] WBG = 4'h4;
  localparam logic [3:0] EXG = 4'h5;
  localparam logic [3:0] DLN = 4'h3;
  localparam logic [3:0] ILN = 4'h2;
  localparam logic [31:0] PF1 = 32'h0000_0011;
  localparam logic [127:0] MMV = 128'h3333_0003_2222_0002_1111_0001_0000_a5a5;
  typedef struct packed {
    logic [31:0] cyc;
    logic [31:0] mask;
    logic [31:0] data;
    logic [31:0] uni;
    logic undef;
    logic twr;
    logic trd;
    logic [2:0] sel;
  } cib_note_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cib_req_s req = '0;
  logic [3:0] cluster_id_pins = 4'h0;
  logic [1:0] core_number = 2'h0;
  logic [18:0] peripheral_base_input = 19'h0;
  cib_rsp_s rsp_r;
  cib_rsp_s rsp_uni;
  logic test_wr_r;
  logic test_rd_r;
  logic [2:0] test_sel_r;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] cyc = '0;
  cib_note_s notes[$];
  // clock and cycle count
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 32'h1;
  cib_bank #(.IMPLEMENTER(IMPL), .MAJOR_REV(MREV), .WB_GRANULE(WBG), .EXCL_GRANULE(EXG),
    .DLINE_LOG2(DLN), .ILINE_LOG2(ILN), .MULTICORE(1'b1), .PF1_VALUE(PF1),
    .MM_VALUES(MMV)) DUT (.clk(clk), .rst_n(rst_n), .req(req),
    .cluster_id_pins(cluster_id_pins), .core_number(core_number),
    .peripheral_base_input(peripheral_base_input), .rsp_r(rsp_r), .test_wr_r(test_wr_r),
    .test_rd_r(test_rd_r), .test_sel_r(test_sel_r));
  // single-core build on the same requests: affinity and configuration base differ
  cib_bank #(.IMPLEMENTER(IMPL), .MAJOR_REV(MREV), .WB_GRANULE(WBG), .EXCL_GRANULE(EXG),
    .DLINE_LOG2(DLN), .ILINE_LOG2(ILN), .MULTICORE(1'b0), .PF1_VALUE(PF1),
    .MM_VALUES(MMV)) dut_uni (.clk(clk), .rst_n(rst_n), .req(req),
    .cluster_id_pins(cluster_id_pins), .core_number(core_number),
    .peripheral_base_input(peripheral_base_input), .rsp_r(rsp_uni), .test_wr_r(),
    .test_rd_r(), .test_sel_r());
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic cib_req_s mk(logic wr, logic pv, logic sc, logic [3:0] crn,
                                  logic [2:0] o1, logic [3:0] crm, logic [2:0] o2);
    cib_req_s r;
    r = '{1'b1, wr, pv, sc, crn, o1, crm, o2, 32'($urandom)};
    return r;
  endfunction
  // expected id word from the current pin values
  function automatic logic [31:0] exp_val(logic [3:0] crm, logic [2:0] o2, logic mc);
    if (crm == 4'h1) begin
      case (o2)
        3'h0: return 32'h0000_1231;
        3'h1: return PF1;
        3'h2: return 32'h0001_0444;
        3'h3: return 32'h0000_0000;
        default: return MMV[32*(int'(o2)-4) +: 32];
      endcase
    end
    case (o2)
      3'h0: return {IMPL, MREV, 20'h0};
      3'h1: return {3'h4, 1'b0, WBG, EXG, DLN, 2'h2, 10'h0, ILN};
      3'h3: return 32'h0000_0400;
      3'h5: return {1'b1, !mc, 18'h0, cluster_id_pins, 6'h0, (mc ? core_number : 2'h0)};
      default: return 32'h0000_0000;
    endcase
  endfunction
  function automatic logic [31:0] mask_of(logic [3:0] crm, logic [2:0] o2);
    if (crm == 4'h0 && o2 == 3'h0) return 32'hfff0_0000;
    if (crm == 4'h0 && o2 == 3'h3) return 32'h00ff_ff01;
    return 32'hffff_ffff;
  endfunction
  // drive one request at the falling edge and note what must come back
  task automatic acc(input cib_req_s r, input logic [31:0] mask, input logic [31:0] exp,
                     input logic [31:0] uexp, input logic undef, input logic twr,
                     input logic trd);
    notes.push_back('{cyc, mask, exp & mask, uexp & mask, undef, twr, trd, r.crm[2:0]});
    req = r;
    @(negedge clk);
  endtask
  task automatic rd_id(input logic wr, input logic pv, input logic [3:0] crm,
                       input logic [2:0] o2);
    cib_req_s r;
    r = mk(wr, pv, 1'($urandom), 4'h0, 3'h0, crm, o2);
    if (!pv) acc(r, 32'hffff_ffff, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
    else if (wr) acc(r, 32'hffff_ffff, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
    else acc(r, mask_of(crm, o2), exp_val(crm, o2, 1'b1), exp_val(crm, o2, 1'b0),
             1'b0, 1'b0, 1'b0);
  endtask
  task automatic idle();
    req.valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic do_reset(input logic [18:0] base);
    rst_n = 1'b0;
    peripheral_base_input = base;
    repeat (3) @(negedge clk);
    check("rsp_valid_in_reset", {31'h0, rsp_r.valid}, 32'h0);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd_cfg(input logic [18:0] base);
    acc(mk(1'b0, 1'b1, 1'($urandom), 4'hf, 3'h4, 4'h0, 3'h0), 32'hffff_ffff,
        {base, 13'h0}, 32'h0, 1'b0, 1'b0, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // response monitor: oldest note against each answer
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    cib_note_s n;
    if (rsp_r.valid === 1'b1) begin
      if (notes.size() == 0) check("unexpected_rsp", 32'h1, 32'h0);
      else begin
        n = notes.pop_front();
        check("rsp_latency", cyc, n.cyc + 32'h1);
        check("rdata", rsp_r.rdata & n.mask, n.data);
        check("rdata_uni", rsp_uni.rdata & n.mask, n.uni);
        check("undef_uni", {31'h0, rsp_uni.undef}, {31'h0, n.undef});
        check("undef", {31'h0, rsp_r.undef}, {31'h0, n.undef});
        check("test_strobes", {30'h0, test_wr_r, test_rd_r}, {30'h0, n.twr, n.trd});
        if (n.twr | n.trd) check("test_sel", {29'h0, test_sel_r}, {29'h0, n.sel});
      end
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [18:0] base;
    logic [3:0] crm;
    i = $urandom(52);
    base = 19'($urandom);
    @(negedge clk);
    do_reset(base);
    // writes to every id word, then reads, then unprivileged accesses
    for (i = 0; i < 48; i++) begin
      cluster_id_pins = 4'($urandom);
      core_number = 2'($urandom);
      rd_id(i < 16, i < 32, {3'h0, i[3]}, i[2:0]);
    end
    rd_cfg(base);
    // buffer test registers in both security states, back to back
    for (i = 0; i < 8; i++) begin
      crm = {2'h1, i[1:0]};
      acc(mk(crm == 4'h4, 1'b1, i[2], 4'hf, 3'h4, crm, (crm == 4'h4) ? 3'h4 : 3'h2), 32'h0,
          32'h0, 32'h0, !i[2], i[2] && crm == 4'h4, i[2] && crm != 4'h4);
    end
    acc(mk(1'b0, 1'b1, 1'b1, 4'hf, 3'h4, 4'h4, 3'h4), 32'h0, 32'h0, 32'h0,
        1'b1, 1'b0, 1'b0);
    idle();
    // a second reset picks up a new peripheral base
    base = 19'($urandom);
    do_reset(base);
    rd_cfg(base);
    rd_id(1'b0, 1'b1, 4'h0, 3'h5);
    idle();
    check("pending_notes", 32'(notes.size()), 32'h0);
    stop_test();
  end
  // watchdog
  initial begin
    #(8 * 2000);
    errors++;
    stop_test();
  end
endmodule // cib_bank_bench
`default_nettype wire
